// ---- core_model.sv ----
// partner model of the core's sleep, wake and startup-timer logic
`timescale 1ns/100ps
`default_nettype none
module core_model #(
    parameter int STARTUP_CYCLES = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep_req,
    input wire logic crystal_clock_sel,
    input wire logic wake_request,
    input wire logic device_reset,
    output logic sleep_active,
    output logic osc_startup_timer
);
    logic [7:0] startup_ff;
    // ----------------------------
    // sleep state and startup timer
    // ----------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_active <= 1'b0;
        end else if (wake_request || device_reset) begin
            sleep_active <= 1'b0;
        end else if (sleep_req) begin
            sleep_active <= 1'b1;
        end
    end
    // crystal clock restarts on wake, so the timer runs after a wake_request exit, not after a device_reset exit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_ff <= 8'h00;
        end else if (wake_request && crystal_clock_sel) begin
            startup_ff <= 8'(STARTUP_CYCLES);
        end else if (startup_ff != 8'h00) begin
            startup_ff <= startup_ff - 8'h01;
        end
    end
    assign osc_startup_timer = (startup_ff != 8'h00);
endmodule : core_model
`default_nettype wire

// ---- watchdog_defs.svh ----
// constants for the watchdog block
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// register byte offsets (printed offset is not a multiple of four: index * 4)
`define WD_CONTROL_IDX 12'h097
`define WD_CONTROL_ADDR 12'h25c
`define WD_STATUS_ADDR 12'h260
`define WD_MASK_ADDR 12'h264
`define WD_FLAGS_ADDR 12'h268

// watchdog_control fields
`define WD_EN_BIT 0
`define WD_PS_LSB 1
`define WD_PS_MSB 5
`define WD_CONTROL_RESET 8'h16
`define WD_PS_MAX 5'h12
`define WD_PS_BASE 5

// status / mask bits
`define WD_EV_TIMEOUT 0
`define WD_EV_WAKE 1
`define WD_EV_W 2

// timing
`define WD_CLK_HZ 40000000
`define WD_TICK_HZ 31000
`define WD_TICK_CYCLES (`WD_CLK_HZ / `WD_TICK_HZ)
`define WD_TICK_CW 11
`define WD_CNT_W 24

`endif

// ---- watchdog_pkg.sv ----
// types shared by the watchdog block
package watchdog_pkg;
    typedef enum logic [1:0] {
        CFG_OFF,
        CFG_SOFT,
        CFG_AWAKE,
        CFG_ALWAYS
    } config_mode_t;
endpackage : watchdog_pkg

// ---- watchdog_timer.sv ----
// watchdog timer with sleep handling and apb registers
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_defs.svh"

module watchdog_timer
    import watchdog_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] watchdog_config_mode,
    input wire logic watchdog_clear_instruction,
    input wire logic sleep_active,
    input wire logic osc_fail,
    input wire logic crystal_clock_sel,
    input wire logic osc_startup_timer,
    input wire logic [3:0] internal_osc_divider,
    output logic device_reset,
    output logic wake_request,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic irq
);

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic [7:0] control_ff;
    logic [`WD_EV_W-1:0] status_ff;
    logic [`WD_EV_W-1:0] mask_ff;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [4:0] period_sel;
    logic soft_watchdog_enable;

    assign hit = (paddr == `WD_CONTROL_ADDR) || (paddr == `WD_STATUS_ADDR) ||
                 (paddr == `WD_MASK_ADDR) || (paddr == `WD_FLAGS_ADDR);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign period_sel = control_ff[`WD_PS_MSB:`WD_PS_LSB];
    assign soft_watchdog_enable = control_ff[`WD_EN_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_ff <= `WD_CONTROL_RESET;
        end else if (wr_en && paddr == `WD_CONTROL_ADDR) begin
            control_ff <= {2'h0, pwdata[5:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= '0;
        end else if (wr_en && paddr == `WD_MASK_ADDR) begin
            mask_ff <= pwdata[`WD_EV_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `WD_CONTROL_ADDR: prdata <= {24'h0, control_ff};
                `WD_STATUS_ADDR: prdata <= {30'h0, status_ff};
                `WD_MASK_ADDR: prdata <= {30'h0, mask_ff};
                `WD_FLAGS_ADDR: prdata <= {30'h0, power_down_flag, timeout_flag};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    config_mode_t mode;
    logic active;
    logic sleep_d_ff;
    logic sleep_enter;
    logic sleep_exit;
    logic startup_hold_ff;

    assign mode = config_mode_t'(watchdog_config_mode);

    always_comb begin
        case (mode)
            CFG_ALWAYS: active = 1'b1;
            CFG_AWAKE: active = !sleep_active;
            CFG_SOFT: active = soft_watchdog_enable;
            default: active = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_d_ff <= 1'b0;
        end else begin
            sleep_d_ff <= sleep_active;
        end
    end

    assign sleep_enter = sleep_active && !sleep_d_ff;
    assign sleep_exit = !sleep_active && sleep_d_ff;

    // crystal clocks keep the count clear until the startup timer ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_hold_ff <= 1'b0;
        end else if (sleep_exit && crystal_clock_sel) begin
            startup_hold_ff <= 1'b1;
        end else if (!osc_startup_timer) begin
            startup_hold_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // tick prescaler and timeout counter
    // ----------------------------------------
    logic [`WD_TICK_CW-1:0] tick_div_ff;
    logic tick;
    logic [`WD_CNT_W-1:0] count_ff;
    logic [`WD_CNT_W-1:0] limit;
    logic clear_now;
    logic expire;

    // the ~31 kHz tick is derived from pclk; internal_osc_divider never reaches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_div_ff <= '0;
        end else if (tick_div_ff == `WD_TICK_CW'(`WD_TICK_CYCLES - 1)) begin
            tick_div_ff <= '0;
        end else begin
            tick_div_ff <= tick_div_ff + 1'b1;
        end
    end
    assign tick = (tick_div_ff == `WD_TICK_CW'(`WD_TICK_CYCLES - 1));

    // reserved codes fall back to the shortest interval
    always_comb begin
        if (period_sel > `WD_PS_MAX) begin
            limit = `WD_CNT_W'(1) << `WD_PS_BASE;
        end else begin
            limit = `WD_CNT_W'(1) << (period_sel + 5'(`WD_PS_BASE));
        end
    end

    assign clear_now = !active || watchdog_clear_instruction || sleep_enter || sleep_exit ||
                       osc_fail || startup_hold_ff || osc_startup_timer;
    assign expire = tick && (count_ff >= limit - 1'b1) && !clear_now;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
        end else if (clear_now) begin
            count_ff <= '0;
        end else if (expire) begin
            count_ff <= '0;
        end else if (tick) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // ----------------------------------------
    // timeout actions and flags
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_reset <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            device_reset <= expire && !sleep_active;
            wake_request <= expire && sleep_active;
        end
    end

    // active-low style status: timeout_flag low after a timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (expire) begin
            timeout_flag <= 1'b0;
            power_down_flag <= !sleep_active;
        end else if (watchdog_clear_instruction) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end
    end

    // a read clears only the bits it returned, so an event landing after the
    // setup cycle stays pending; set still wins over the clear
    logic [`WD_EV_W-1:0] rd_clear;
    assign rd_clear = (rd_en && paddr == `WD_STATUS_ADDR) ? prdata[`WD_EV_W-1:0] :
                      `WD_EV_W'(0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~rd_clear) |
                         {expire && sleep_active, expire};
        end
    end

    assign irq = |(status_ff & mask_ff);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    disabled_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        !active |=> count_ff == '0) else $error("counter not clear while disabled");
    always_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == CFG_ALWAYS |-> active) else $error("mode 11 not active");
    sleep_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == CFG_AWAKE && sleep_active) |-> !active) else $error("mode 10 active asleep");
    clear_instr_a: assert property (@(posedge pclk) disable iff (!presetn)
        watchdog_clear_instruction |=> count_ff == '0) else $error("clear ignored");
    sleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (expire && sleep_active) |=> wake_request && !device_reset && !timeout_flag)
        else $error("sleep timeout not a wake");
    awake_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (expire && !sleep_active) |=> device_reset && !wake_request)
        else $error("awake timeout no reset");
    restart_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        expire |=> count_ff == '0) else $error("counter not restarted");
    startup_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_exit && crystal_clock_sel) |=> (count_ff == '0) [*2])
        else $error("count during startup");
    tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick) else $error("tick too fast");
    reserved_min_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_sel > `WD_PS_MAX |-> limit == `WD_CNT_W'(32)) else $error("reserved not min");
    soft_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == CFG_SOFT |-> active == soft_watchdog_enable)
        else $error("mode 01 ignores soft enable");
    off_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == CFG_OFF |=> count_ff == '0)
        else $error("counter runs in mode 00");
    enter_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_enter |=> count_ff == '0)
        else $error("sleep entry did not clear");
    exit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_exit |=> count_ff == '0)
        else $error("sleep exit did not clear");
    fail_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        osc_fail |=> count_ff == '0)
        else $error("oscillator failure did not clear");
    timer_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (osc_startup_timer || startup_hold_ff) |=> count_ff == '0)
        else $error("count while startup timer runs");
    tick_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!tick && !clear_now) |=> $stable(count_ff))
        else $error("count moved without a tick");
    div_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(internal_osc_divider) && !tick && !clear_now) |=> $stable(count_ff))
        else $error("divider change moved the count");
    code_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_sel <= `WD_PS_MAX |-> $onehot(limit) && limit >= `WD_CNT_W'(32))
        else $error("period outside its range");
    longest_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_sel == `WD_PS_MAX |-> limit[`WD_CNT_W-1])
        else $error("longest period wrong");
    reset_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        device_reset |=> !device_reset)
        else $error("reset request longer than a cycle");
    wake_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        wake_request |=> !wake_request)
        else $error("wake request longer than a cycle");
    status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        expire |=> status_ff[`WD_EV_TIMEOUT])
        else $error("timeout not latched in status");
    flags_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        watchdog_clear_instruction |=> timeout_flag && power_down_flag)
        else $error("clear instruction left flags low");
    sleep_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        (expire && sleep_active) |=> !power_down_flag && status_ff[`WD_EV_WAKE])
        else $error("sleep timeout flags wrong");

endmodule : watchdog_timer
`default_nettype wire

// ---- watchdog_timer_with_sleep_modes_tb.sv ----
// self-checking bench for the watchdog timer
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_defs.svh"
module watchdog_timer_with_sleep_modes_tb
    import watchdog_pkg::*;
;
    localparam int TICK = `WD_TICK_CYCLES;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, device_reset, wake_request, timeout_flag, power_down_flag, irq;
    logic clr_ins = 1'b0, osc_fail = 1'b0, sleep_req = 1'b0, sleep_active, osc_startup_timer;
    logic [1:0] cfg = 2'h0;
    logic [3:0] div = 4'h0;
    logic xtal = 1'b1;
    int n_mismatch = 0, n_tests = 0, n;
    always #12.5 pclk = ~pclk;
    watchdog_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_config_mode(cfg), .watchdog_clear_instruction(clr_ins),
        .sleep_active(sleep_active), .osc_fail(osc_fail), .crystal_clock_sel(xtal),
        .osc_startup_timer(osc_startup_timer), .internal_osc_divider(div),
        .device_reset(device_reset), .wake_request(wake_request),
        .timeout_flag(timeout_flag), .power_down_flag(power_down_flag), .irq(irq));
    core_model PARTNER (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
        .crystal_clock_sel(xtal), .wake_request(wake_request), .device_reset(device_reset),
        .sleep_active(sleep_active), .osc_startup_timer(osc_startup_timer));
    // ----------------------------
    // tasks
    // ----------------------------
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    task automatic pulse_clear();
        @(posedge pclk);
        clr_ins <= 1'b1;
        @(posedge pclk);
        clr_ins <= 1'b0;
    endtask : pulse_clear
    // a timeout is at least 31 ticks away, the tick phase is unknown
    task automatic wait_evt(input logic slp);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((slp ? wake_request : device_reset) !== 1'b1 && n < 34 * TICK);
        if (n >= 34 * TICK) begin
            n_mismatch++;
            end_of_test();
        end
        chk({31'h0, n >= 31 * TICK - 4 && n <= 33 * TICK + 4}, 32'h1);
    endtask : wait_evt
    // ----------------------------
    // main sequence
    // ----------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`WD_CONTROL_ADDR, {24'h0, `WD_CONTROL_RESET});
        rd(`WD_FLAGS_ADDR, 32'h3);
        rd(12'h004, 32'h0);
        chk({31'h0, err}, 32'h1);
        cfg <= CFG_SOFT;
        apb(1'b1, `WD_CONTROL_ADDR, 32'hc1);
        rd(`WD_CONTROL_ADDR, 32'h01);
        apb(1'b1, `WD_MASK_ADDR, 32'h3);
        osc_fail <= 1'b1;
        @(posedge pclk);
        osc_fail <= 1'b0;
        repeat (200) @(posedge pclk);
        pulse_clear();
        div <= 4'h5;
        wait_evt(1'b0);
        rd(`WD_FLAGS_ADDR, 32'h2);
        chk({31'h0, irq}, 32'h1);
        rd(`WD_STATUS_ADDR, 32'h1);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `WD_MASK_ADDR, 32'h0);
        // reserved period code: the sleep timeout below must still take 32 ticks
        apb(1'b1, `WD_CONTROL_ADDR, 32'h3f);
        cfg <= CFG_AWAKE;
        pulse_clear();
        @(negedge pclk);
        chk({31'h0, timeout_flag}, 32'h1);
        @(posedge pclk);
        sleep_req <= 1'b1;
        @(posedge pclk);
        sleep_req <= 1'b0;
        // mode 10 keeps the count clear in sleep, so the wake is timed from the switch
        repeat (6 * TICK) @(posedge pclk);
        chk({31'h0, sleep_active}, 32'h1);
        cfg <= CFG_ALWAYS;
        wait_evt(1'b1);
        repeat (3) @(posedge pclk);
        chk({31'h0, sleep_active}, 32'h0);
        chk({30'h0, power_down_flag, timeout_flag}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, `WD_STATUS_ADDR, 32'h0);
        chk(q & 32'h2, 32'h2);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`WD_CONTROL_ADDR, {24'h0, `WD_CONTROL_RESET});
        rd(`WD_FLAGS_ADDR, 32'h3);
        rd(`WD_STATUS_ADDR, 32'h0);
        end_of_test();
    end
endmodule : watchdog_timer_with_sleep_modes_tb
`default_nettype wire
